// ---- rtl/phy_cfg_pkg.sv ----
package phy_cfg_pkg;

  // management register offsets
  localparam logic [4:0] ADDR_BASIC_MODE_CONTROL   = 5'h00;
  localparam logic [4:0] ADDR_BASIC_MODE_STATUS    = 5'h01;
  localparam logic [4:0] ADDR_NEG_ADVERTISEMENT    = 5'h04;
  localparam logic [4:0] ADDR_PARTNER_ABILITY      = 5'h05;
  localparam logic [4:0] ADDR_NEG_EXPANSION        = 5'h06;
  localparam logic [4:0] ADDR_PHY_STATUS           = 5'h10;
  localparam logic [4:0] ADDR_PHY_CONTROL          = 5'h19;

  // basic control bit positions
  localparam int BMC_SPEED   = 13;
  localparam int BMC_NEGOTIATE_STRAP_ENABLE   = 12;
  localparam int BMC_ISOLATE = 10;
  localparam int BMC_RESTART = 9;
  localparam int BMC_DUPLEX  = 8;

  // ability field (100 full, 100 half, 10 full, 10 half) and selector
  localparam int             ABIL_HI      = 8;
  localparam int             ABIL_LO      = 5;
  localparam logic [4:0]     SELECTOR_STD = 5'h01;
  localparam logic [15:0]    PD_WORD_100  = 16'h0081;
  localparam logic [15:0]    PD_WORD_10   = 16'h0021;
  localparam int             LP_REMOTE_FAULT = 13;
  localparam int             LP_NEXT_PAGE    = 15;

  // fixed basic status: all abilities but T4, preamble suppression,
  // negotiation ability, extended registers
  localparam logic [15:0] BASIC_STATUS_FIXED = 16'h7849;
  localparam int          BMS_AN_COMPLETE    = 5;
  localparam int          BMS_REMOTE_FAULT   = 4;
  localparam int          BMS_LINK           = 2;

  // phy control bit positions
  localparam int          PCR_MDIX_EN    = 15;
  localparam int          PCR_FORCED_CROSSOVER_BIT = 14;
  localparam logic [4:0]  ISOLATE_ADDR   = 5'h00;

  // timing
  localparam int CLK_HZ           = 125_000_000;
  localparam int BREAK_LINK_MS    = 1500;
  localparam int NEG_TIMEOUT_MS   = 3000;
  localparam int MDIX_SLOT_MS     = 62;
  localparam int BREAK_LINK_CYC   = CLK_HZ / 1000 * BREAK_LINK_MS;
  localparam int NEG_TIMEOUT_CYC  = CLK_HZ / 1000 * NEG_TIMEOUT_MS;
  localparam int MDIX_SLOT_CYC    = CLK_HZ / 1000 * MDIX_SLOT_MS;

  // management frame bit counts after the start pattern
  localparam logic [4:0] MF_REG_LAST  = 5'd11;
  localparam logic [4:0] MF_TA_FIRST  = 5'd12;
  localparam logic [4:0] MF_DATA_LAST = 5'd29;
  localparam logic [1:0] MF_OP_WRITE  = 2'b01;
  localparam logic [1:0] MF_OP_READ   = 2'b10;

  // negotiation states, gray along forced->break->ability->complete
  typedef enum logic [1:0] {
    NS_FORCED   = 2'b00,
    NS_BREAK    = 2'b01,
    NS_ABILITY  = 2'b11,
    NS_COMPLETE = 2'b10
  } neg_state_t;

endpackage : phy_cfg_pkg

// ---- rtl/mode_resolver.sv ----
module mode_resolver
  import phy_cfg_pkg::*;
(
  // ability sets, bit 3 = 100 full ... bit 0 = 10 half
  input  wire logic [3:0] local_abil_in,
  input  wire logic [3:0] partner_abil_in,
  // resolved mode
  output logic            valid_out,
  output logic            speed_100_out,
  output logic            full_duplex_out
);

  logic [3:0] common;

  // highest common ability wins
  always_comb begin
    common          = local_abil_in & partner_abil_in;
    valid_out       = |common;
    speed_100_out   = 1'b0;
    full_duplex_out = 1'b0;
    if (common[3]) begin
      speed_100_out   = 1'b1;
      full_duplex_out = 1'b1;
    end else if (common[2]) begin
      speed_100_out   = 1'b1;
    end else if (common[1]) begin
      full_duplex_out = 1'b1;
    end
  end

endmodule : mode_resolver

// ---- rtl/mgmt_frame_slave.sv ----
module mgmt_frame_slave
  import phy_cfg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // serial management pins
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_out,
  // own address
  input  wire logic [4:0]  station_addr_in,
  // register access
  output logic [4:0]       reg_addr_out,
  output logic             rd_pulse_out,
  input  wire logic [15:0] rd_data_in,
  output logic             wr_pulse_out,
  output logic [15:0]      wr_data_out
);

  logic        mdc_prev_r;
  logic        in_frame_r;
  logic        last_bit_r;
  logic [4:0]  cnt_r;
  logic [1:0]  op_r;
  logic [4:0]  phy_r;
  logic [15:0] sh_r;
  logic        talk_r;
  logic        rise;

  assign rise = mdc_in & ~mdc_prev_r;

  // bits are taken on mdc rising edges; preamble is optional
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mdc_prev_r   <= mdc_in;  // no false rise if mdc is left high at release
      in_frame_r   <= 1'b0;
      last_bit_r   <= 1'b1;
      cnt_r        <= '0;
      op_r         <= '0;
      phy_r        <= '0;
      reg_addr_out <= '0;
      sh_r         <= '0;
      talk_r       <= 1'b0;
      mdio_out     <= 1'b1;
      mdio_oe_out  <= 1'b0;
      rd_pulse_out <= 1'b0;
      wr_pulse_out <= 1'b0;
      wr_data_out  <= '0;
    end else begin
      mdc_prev_r   <= mdc_in;
      rd_pulse_out <= 1'b0;
      wr_pulse_out <= 1'b0;
      if (rise) begin
        last_bit_r <= mdio_in;
        if (!in_frame_r) begin
          // start pattern 0 then 1
          if (!last_bit_r && mdio_in) begin
            in_frame_r <= 1'b1;
            cnt_r      <= '0;
          end
        end else begin
          cnt_r <= cnt_r + 5'd1;
          if (cnt_r < 5'd2) begin
            op_r <= {op_r[0], mdio_in};
          end else if (cnt_r < 5'd7) begin
            phy_r <= {phy_r[3:0], mdio_in};
          end else if (cnt_r <= MF_REG_LAST) begin
            reg_addr_out <= {reg_addr_out[3:0], mdio_in};
          end
          if (cnt_r == MF_REG_LAST) begin
            talk_r       <= (op_r == MF_OP_READ) && (phy_r == station_addr_in);
          end
          if (cnt_r == MF_TA_FIRST && talk_r) begin
            // clear-on-read strobe leaves with the snapshot, so cleared flags still read set
            sh_r         <= rd_data_in;
            rd_pulse_out <= 1'b1;
            mdio_oe_out <= 1'b1;
            mdio_out    <= 1'b0;           // turnaround zero
          end else if (cnt_r > MF_TA_FIRST && talk_r) begin
            mdio_out <= sh_r[15];
            sh_r     <= {sh_r[14:0], 1'b0};
          end else if (cnt_r > MF_TA_FIRST + 5'd1) begin
            sh_r <= {sh_r[14:0], mdio_in};
          end
          if (cnt_r == MF_DATA_LAST) begin
            in_frame_r  <= 1'b0;
            talk_r      <= 1'b0;
            mdio_oe_out <= 1'b0;
            last_bit_r  <= 1'b1;
            if (op_r == MF_OP_WRITE && phy_r == station_addr_in) begin
              wr_pulse_out <= 1'b1;
              wr_data_out  <= {sh_r[14:0], mdio_in};
            end
          end
        end
      end
    end
  end

endmodule : mgmt_frame_slave

// ---- rtl/phy_autoneg_config.sv ----
module phy_autoneg_config
  import phy_cfg_pkg::*;
#(
  parameter int BREAK_CYCLES   = BREAK_LINK_CYC,
  parameter int TIMEOUT_CYCLES = NEG_TIMEOUT_CYC,
  parameter int MDIX_CYCLES    = MDIX_SLOT_CYC
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // configuration straps
  input  wire logic        negotiate_strap_enable_in,
  input  wire logic        ability_strap_high_in,
  input  wire logic        ability_strap_low_in,
  input  wire logic [4:0]  station_address_strap_in,
  input  wire logic        crossover_strap_in,
  // serial management
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_out,
  // link partner pages and receiver link status
  input  wire logic        page_rx_valid_in,
  input  wire logic [15:0] page_rx_word_in,
  input  wire logic        link_100_good_in,
  input  wire logic        link_10_good_in,
  // line side control
  output logic             burst_tx_enable_out,
  output logic [15:0]      burst_tx_word_out,
  output logic             line_quiet_out,
  output logic             crossover_out,
  output logic             link_up_out,
  output logic             speed_100_out,
  output logic             full_duplex_out,
  // mac side control
  output logic             mii_out_enable_out,
  output logic             tx_accept_out
);

  logic [15:0] basic_mode_control_r;
  logic [3:0]  adv_abil_r;
  logic [15:0] partner_ability_r;
  logic [15:0] phy_control_r;
  logic        an_armed_r;
  logic        an_prev_r;
  logic        strap_isolate_r;
  logic        pd_fault_r;
  logic        page_rcvd_r;
  logic        lp_an_able_r;
  logic        page_seen_r;
  neg_state_t  state_r;
  neg_state_t  state_nxt;
  logic [31:0] timer_r;
  logic [31:0] slot_r;
  logic [7:0]  lfsr_r;
  logic        res_speed_r;
  logic        res_duplex_r;

  logic [4:0]  reg_addr;
  logic        rd_pulse;
  logic        wr_pulse;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic        an_active;
  logic        restart_req;
  logic        one_link;
  logic        res_valid;
  logic        res_speed;
  logic        res_duplex;
  logic        sel_link;

  // address decode shared by writes and clear-on-read
  function automatic logic hit(input logic [4:0] a, input logic [4:0] want);
    hit = (a == want);
  endfunction : hit

  // strap code to advertised ability set (100f,100h,10f,10h)
  function automatic logic [3:0] strap_abil(input logic en, input logic hi,
                                            input logic lo);
    logic [1:0] code;
    code = {hi, lo};
    if (!en) begin
      strap_abil = 4'h1 << code;
    end else begin
      case (code)
        2'b00:   strap_abil = 4'h3;
        2'b01:   strap_abil = 4'hC;
        2'b10:   strap_abil = 4'h5;
        default: strap_abil = 4'hF;
      endcase
    end
  endfunction : strap_abil

  mgmt_frame_slave u_mgmt (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .mdc_in          (mdc_in),
    .mdio_in         (mdio_in),
    .mdio_out        (mdio_out),
    .mdio_oe_out     (mdio_oe_out),
    .station_addr_in (phy_control_r[4:0]),
    .reg_addr_out    (reg_addr),
    .rd_pulse_out    (rd_pulse),
    .rd_data_in      (rd_data),
    .wr_pulse_out    (wr_pulse),
    .wr_data_out     (wr_data)
  );

  mode_resolver u_resolve (
    .local_abil_in   (adv_abil_r),
    .partner_abil_in (partner_ability_r[ABIL_HI:ABIL_LO]),
    .valid_out       (res_valid),
    .speed_100_out   (res_speed),
    .full_duplex_out (res_duplex)
  );

  // negotiation is live only once armed; a forced strap needs clear-then-set
  assign an_active   = basic_mode_control_r[BMC_NEGOTIATE_STRAP_ENABLE] & an_armed_r;
  assign one_link    = link_100_good_in ^ link_10_good_in;
  assign sel_link    = res_speed_r ? link_100_good_in : link_10_good_in;
  assign restart_req = (wr_pulse && hit(reg_addr, ADDR_BASIC_MODE_CONTROL)
                        && wr_data[BMC_RESTART])
                     || (an_active && !an_prev_r)
                     || (state_r == NS_COMPLETE && !sel_link);

  // basic control: straps during reset, management writes after
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      basic_mode_control_r              <= '0;
      basic_mode_control_r[BMC_NEGOTIATE_STRAP_ENABLE]   <= negotiate_strap_enable_in;
      basic_mode_control_r[BMC_SPEED]   <= ability_strap_high_in;
      basic_mode_control_r[BMC_DUPLEX]  <= ability_strap_low_in;
      basic_mode_control_r[BMC_ISOLATE] <= station_address_strap_in == ISOLATE_ADDR;
      an_armed_r                        <= negotiate_strap_enable_in;
    end else if (wr_pulse && hit(reg_addr, ADDR_BASIC_MODE_CONTROL)) begin
      basic_mode_control_r[BMC_SPEED]   <= wr_data[BMC_SPEED];
      basic_mode_control_r[BMC_NEGOTIATE_STRAP_ENABLE]   <= wr_data[BMC_NEGOTIATE_STRAP_ENABLE];
      basic_mode_control_r[BMC_ISOLATE] <= wr_data[BMC_ISOLATE];
      basic_mode_control_r[BMC_DUPLEX]  <= wr_data[BMC_DUPLEX];
      if (!wr_data[BMC_NEGOTIATE_STRAP_ENABLE]) begin
        an_armed_r <= 1'b1;
      end
    end
  end

  // advertisement and phy control; address write never touches isolate
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adv_abil_r    <= strap_abil(negotiate_strap_enable_in, ability_strap_high_in,
                                  ability_strap_low_in);
      phy_control_r <= '0;
      phy_control_r[PCR_MDIX_EN] <= crossover_strap_in;
      phy_control_r[4:0]         <= station_address_strap_in;
    end else if (wr_pulse) begin
      if (hit(reg_addr, ADDR_NEG_ADVERTISEMENT)) begin
        adv_abil_r <= wr_data[ABIL_HI:ABIL_LO];
      end
      if (hit(reg_addr, ADDR_PHY_CONTROL)) begin
        phy_control_r[PCR_MDIX_EN]    <= wr_data[PCR_MDIX_EN];
        phy_control_r[PCR_FORCED_CROSSOVER_BIT] <= wr_data[PCR_FORCED_CROSSOVER_BIT];
        phy_control_r[4:0]            <= wr_data[4:0];
      end
    end
  end

  // negotiation state sequence
  always_comb begin
    state_nxt = state_r;
    if (!an_active) begin
      state_nxt = NS_FORCED;
    end else if (restart_req) begin
      state_nxt = NS_BREAK;
    end else begin
      case (state_r)
        NS_BREAK: begin
          if (timer_r == 32'(BREAK_CYCLES - 1)) begin
            state_nxt = NS_ABILITY;
          end
        end
        NS_ABILITY: begin
          if (page_seen_r && res_valid
              && (res_speed ? link_100_good_in : link_10_good_in)) begin
            state_nxt = NS_COMPLETE;
          end else if (!page_seen_r && one_link) begin
            state_nxt = NS_COMPLETE;
          end else if (timer_r == 32'(TIMEOUT_CYCLES - 1)) begin
            state_nxt = NS_BREAK;
          end
        end
        NS_COMPLETE: state_nxt = NS_COMPLETE;
        default:     state_nxt = NS_BREAK;
      endcase
    end
  end

  // state and phase timer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r   <= NS_FORCED;
      timer_r   <= '0;
      an_prev_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      an_prev_r <= an_active;
      timer_r   <= (state_nxt != state_r || restart_req) ? '0 : timer_r + 32'd1;
    end
  end

  // partner pages, parallel detection and resolved mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      partner_ability_r <= '0;
      page_seen_r       <= 1'b0;
      lp_an_able_r      <= 1'b0;
      res_speed_r       <= 1'b0;
      res_duplex_r      <= 1'b0;
    end else if (state_nxt == NS_BREAK && state_r != NS_BREAK) begin
      page_seen_r  <= 1'b0;
      lp_an_able_r <= 1'b0;
    end else if (state_r == NS_ABILITY) begin
      if (page_rx_valid_in) begin
        partner_ability_r <= page_rx_word_in;
        page_seen_r       <= 1'b1;
        lp_an_able_r      <= 1'b1;
      end
      if (state_nxt == NS_COMPLETE) begin
        if (page_seen_r) begin
          res_speed_r  <= res_speed;
          res_duplex_r <= res_duplex;
        end else begin
          partner_ability_r <= link_100_good_in ? PD_WORD_100 : PD_WORD_10;
          res_speed_r       <= link_100_good_in;
          res_duplex_r      <= 1'b0;      // parallel detect cannot see duplex
        end
      end
    end
  end

  // expansion flags: hardware set wins over clear-on-read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pd_fault_r  <= 1'b0;
      page_rcvd_r <= 1'b0;
    end else begin
      if (state_r == NS_ABILITY && !page_seen_r && link_100_good_in
          && link_10_good_in) begin
        pd_fault_r <= 1'b1;
      end else if (rd_pulse && hit(reg_addr, ADDR_NEG_EXPANSION)) begin
        pd_fault_r <= 1'b0;
      end
      if (state_r == NS_ABILITY && page_rx_valid_in) begin
        page_rcvd_r <= 1'b1;
      end else if (rd_pulse && hit(reg_addr, ADDR_NEG_EXPANSION)) begin
        page_rcvd_r <= 1'b0;
      end
    end
  end

  // crossover: forced bit wins; auto hunting only while negotiating
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      crossover_out <= 1'b0;
      slot_r        <= '0;
      lfsr_r        <= 8'h5A;              // any nonzero seed
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      slot_r <= (slot_r == 32'(MDIX_CYCLES - 1)) ? '0 : slot_r + 32'd1;
      if (phy_control_r[PCR_FORCED_CROSSOVER_BIT]) begin
        crossover_out <= 1'b1;
      end else if (!phy_control_r[PCR_MDIX_EN] || !an_active) begin
        crossover_out <= 1'b0;
      end else if (state_r == NS_ABILITY && !page_seen_r && !one_link
                   && slot_r == '0) begin
        crossover_out <= lfsr_r[0];
      end
    end
  end

  // line and mac side outputs, all registered
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      burst_tx_enable_out <= 1'b0;
      burst_tx_word_out   <= '0;
      line_quiet_out      <= 1'b0;
      link_up_out         <= 1'b0;
      speed_100_out       <= 1'b0;
      full_duplex_out     <= 1'b0;
      mii_out_enable_out  <= 1'b0;
      tx_accept_out       <= 1'b0;
    end else begin
      burst_tx_enable_out <= state_r == NS_ABILITY;
      burst_tx_word_out   <= {7'h00, adv_abil_r, SELECTOR_STD};
      line_quiet_out      <= state_r == NS_BREAK;
      if (state_r == NS_FORCED) begin
        speed_100_out   <= basic_mode_control_r[BMC_SPEED];
        full_duplex_out <= basic_mode_control_r[BMC_DUPLEX];
        link_up_out     <= basic_mode_control_r[BMC_SPEED] ? link_100_good_in
                                                           : link_10_good_in;
      end else begin
        speed_100_out   <= res_speed_r;
        full_duplex_out <= res_duplex_r;
        link_up_out     <= state_r == NS_COMPLETE;
      end
      mii_out_enable_out  <= !basic_mode_control_r[BMC_ISOLATE];
      tx_accept_out       <= !basic_mode_control_r[BMC_ISOLATE] && state_r != NS_BREAK;
    end
  end

  // register read mux
  always_comb begin
    rd_data = '0;
    case (reg_addr)
      ADDR_BASIC_MODE_CONTROL: begin
        rd_data = basic_mode_control_r;
        rd_data[BMC_NEGOTIATE_STRAP_ENABLE] = an_active;
      end
      ADDR_BASIC_MODE_STATUS: begin
        rd_data = BASIC_STATUS_FIXED;
        rd_data[BMS_AN_COMPLETE]  = state_r == NS_COMPLETE;
        rd_data[BMS_REMOTE_FAULT] = partner_ability_r[LP_REMOTE_FAULT];
        rd_data[BMS_LINK]         = link_up_out;
      end
      ADDR_NEG_ADVERTISEMENT: rd_data = {7'h00, adv_abil_r, SELECTOR_STD};
      ADDR_PARTNER_ABILITY:   rd_data = partner_ability_r;
      ADDR_NEG_EXPANSION: begin
        rd_data = {11'h000, pd_fault_r, partner_ability_r[LP_NEXT_PAGE],
                   1'b1, page_rcvd_r, lp_an_able_r};
      end
      ADDR_PHY_STATUS: begin
        rd_data = {11'h000, state_r == NS_COMPLETE, 1'b0, full_duplex_out,
                   !speed_100_out, link_up_out};
      end
      ADDR_PHY_CONTROL:       rd_data = phy_control_r;
      default:                rd_data = '0;
    endcase
  end

endmodule : phy_autoneg_config

// ---- verification/phy_autoneg_config_asserts.sv ----
module phy_autoneg_config_asserts
  import phy_cfg_pkg::*;
(
  // watched ports
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        mdio_out,
  input  wire logic        mdio_oe_out,
  input  wire logic        link_100_good_in,
  input  wire logic        link_10_good_in,
  input  wire logic        burst_tx_enable_out,
  input  wire logic [15:0] burst_tx_word_out,
  input  wire logic        line_quiet_out,
  input  wire logic        link_up_out,
  input  wire logic        speed_100_out,
  input  wire logic        mii_out_enable_out,
  input  wire logic        tx_accept_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // turnaround bit driven low, then the pin stays driven for the next 8 cycles
  sequence turn_s;
    !mdio_out ##1 mdio_oe_out [*8];
  endsequence
  // silence phase is a stretch, never a glitch
  sequence quiet_s;
    line_quiet_out [*8];
  endsequence
  mdio_turn_a: assert property ($rose(mdio_oe_out) |-> turn_s)
    else $error("read turnaround wrong");
  quiet_burst_a: assert property (!(line_quiet_out && burst_tx_enable_out))
    else $error("bursts during silence");
  quiet_hold_a: assert property ($rose(line_quiet_out) |-> quiet_s)
    else $error("silence too short");
  quiet_end_a: assert property ($fell(line_quiet_out) |-> ##[0:2] burst_tx_enable_out)
    else $error("no bursts after silence");
  loss_restart_a: assert property ($fell(link_up_out) && !link_100_good_in &&
    !link_10_good_in |-> ##[0:4] line_quiet_out) else $error("no restart on loss");
  iso_tx_a: assert property (!mii_out_enable_out |-> !tx_accept_out)
    else $error("transmit taken while isolated");
  burst_sel_a: assert property (burst_tx_enable_out [*2] |->
    burst_tx_word_out[4:0] == SELECTOR_STD) else $error("bad selector in burst");
  link_recv_a: assert property ($rose(link_up_out) |->
    (speed_100_out ? link_100_good_in : link_10_good_in)) else $error("link without receiver");
endmodule : phy_autoneg_config_asserts

bind phy_autoneg_config phy_autoneg_config_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .link_100_good_in(link_100_good_in),
  .link_10_good_in(link_10_good_in), .burst_tx_enable_out(burst_tx_enable_out),
  .burst_tx_word_out(burst_tx_word_out), .line_quiet_out(line_quiet_out),
  .link_up_out(link_up_out), .speed_100_out(speed_100_out),
  .mii_out_enable_out(mii_out_enable_out), .tx_accept_out(tx_accept_out));

// ---- verification/link_partner_model.sv ----
module link_partner_model (
  // clock, reset and line activity seen from the device
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        burst_in,
  // page the partner offers
  input  wire logic        send_in,
  input  wire logic [15:0] word_in,
  // received page towards the device
  output logic             page_valid_out,
  output logic [15:0]      page_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  // answer only while bursts are heard; word toggles when not valid so stale data shows
  always_ff @(posedge clk_in) begin
    wait_r         <= (burst_in && !rst_in) ? wait_r + 4'h1 : 4'h0;
    page_valid_out <= send_in && burst_in && wait_r == 4'h5;
    page_word_out  <= (send_in && wait_r == 4'h5) ? word_in : ~page_word_out;
  end
endmodule : link_partner_model

// ---- verification/phy_autoneg_config_tb_top.sv ----
module phy_autoneg_config_tb_top;
  import phy_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0, rst_in = 1'b1, mdc_in = 1'b0, mdio_tb = 1'b1;
  logic        good_100 = 1'b0, good_10 = 1'b0, send = 1'b0;
  logic        an_s = 1'b1, lo_s = 1'b1, xover;
  logic [4:0]  ad_s = 5'h03;
  logic        mdio_out, mdio_oe, pv, bt_en, quiet, link, spd, fdx, mii_en, tx_acc;
  logic [15:0] pw, bt_word, rd;
  int          bad_count = 0, total_checks = 0;
  // pin level: device drives when enabled, else the bench drives it
  wire         mdio_w = mdio_oe ? mdio_out : mdio_tb;
  always #4 clk_in = ~clk_in;
  phy_autoneg_config #(.BREAK_CYCLES(20), .TIMEOUT_CYCLES(200), .MDIX_CYCLES(8)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .negotiate_strap_enable_in(an_s),
    .ability_strap_high_in(1'b1), .ability_strap_low_in(lo_s),
    .station_address_strap_in(ad_s), .crossover_strap_in(1'b1), .mdc_in(mdc_in),
    .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe), .page_rx_valid_in(pv),
    .page_rx_word_in(pw), .link_100_good_in(good_100), .link_10_good_in(good_10),
    .burst_tx_enable_out(bt_en), .burst_tx_word_out(bt_word), .line_quiet_out(quiet),
    .crossover_out(xover), .link_up_out(link), .speed_100_out(spd), .full_duplex_out(fdx),
    .mii_out_enable_out(mii_en), .tx_accept_out(tx_acc));
  link_partner_model u_lp (.clk_in(clk_in), .rst_in(rst_in), .burst_in(bt_en),
    .send_in(send), .word_in(16'h01E1), .page_valid_out(pv), .page_word_out(pw));
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait on a level, judged when the wait ends
  task automatic wait_hi(ref logic s, input int n);
    repeat (n) if (s !== 1'b1) @(posedge clk_in);
    chk({15'h0000, s}, 16'h0001);
  endtask : wait_hi
  // one whole frame; read data sampled just before each data rise
  task automatic mf(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd = 0);
    logic [31:0] f;
    f = {2'b01, op, ad_s, ra, (op == MF_OP_READ) ? 18'h3_FFFF : {2'b10, wd}};
    for (int i = 31; i >= 0; i--) begin
      mdio_tb <= f[i];
      mdc_in  <= 1'b0;
      repeat (4) @(posedge clk_in);
      rd = {rd[14:0], mdio_w};
      mdc_in  <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask : mf
  task automatic t_reset;
    mf(MF_OP_READ, ADDR_NEG_ADVERTISEMENT);
    chk(rd, 16'h01E1);
    mf(MF_OP_READ, ADDR_BASIC_MODE_STATUS);
    chk(rd & BASIC_STATUS_FIXED, BASIC_STATUS_FIXED);
  endtask : t_reset
  task automatic t_neg;
    mf(MF_OP_WRITE, ADDR_NEG_ADVERTISEMENT, 16'h00E1);
    mf(MF_OP_WRITE, ADDR_BASIC_MODE_CONTROL, 16'h1200);
    wait_hi(quiet, 40);
    wait_hi(bt_en, 60);
    chk(bt_word, 16'h00E1);
    // partner pages come before its receiver reports link, else it looks parallel-detected
    send     <= 1'b1;
    repeat (12) @(posedge clk_in);
    good_100 <= 1'b1;
    wait_hi(link, 200);
    chk({13'h0000, link, spd, fdx}, 16'h0006);
    mf(MF_OP_READ, ADDR_PARTNER_ABILITY);
    chk(rd, 16'h01E1);
    mf(MF_OP_READ, ADDR_PHY_STATUS);
    chk(rd & 16'h0007, 16'h0001);
  endtask : t_neg
  // partner falls back to plain 10 Mb/s signalling after the link drops
  task automatic t_loss;
    send     <= 1'b0;
    good_100 <= 1'b0;
    wait_hi(quiet, 20);
    // both receivers good in the first ability cycles raise the fault flag
    good_10  <= 1'b1;
    good_100 <= 1'b1;
    wait_hi(bt_en, 40);
    good_100 <= 1'b0;
    wait_hi(link, 400);
    chk({13'h0000, link, spd, fdx}, 16'h0004);
    mf(MF_OP_READ, ADDR_PARTNER_ABILITY);
    chk(rd, 16'h0021);
    mf(MF_OP_READ, ADDR_NEG_EXPANSION);
    chk(rd, 16'h0016);
    mf(MF_OP_READ, ADDR_NEG_EXPANSION);
    chk(rd, 16'h0004);
  endtask : t_loss
  task automatic t_forced;
    mf(MF_OP_WRITE, ADDR_BASIC_MODE_CONTROL, 16'h2100);
    chk({12'h000, mii_en, tx_acc, spd, fdx}, 16'h000F);
  endtask : t_forced
  task automatic t_iso;
    mf(MF_OP_WRITE, ADDR_BASIC_MODE_CONTROL, 16'h2500);
    chk({14'h0000, mii_en, tx_acc}, 16'h0000);
    mf(MF_OP_READ, ADDR_PHY_CONTROL);
    chk(rd & 16'h001F, 16'h0003);
  endtask : t_iso
  // mid-run reset re-straps: address zero isolates, straps force 100 half
  task automatic t_straps;
    {rst_in, an_s, lo_s, ad_s} <= {1'b1, 1'b0, 1'b0, 5'h00};
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    mf(MF_OP_READ, ADDR_BASIC_MODE_CONTROL);
    chk(rd, 16'h2400);
    chk({13'h0000, mii_en, spd, fdx}, 16'h0002);
    mf(MF_OP_READ, ADDR_NEG_ADVERTISEMENT);
    chk(rd, 16'h0081);
    mf(MF_OP_WRITE, ADDR_BASIC_MODE_CONTROL, 16'h1000);
    mf(MF_OP_READ, ADDR_BASIC_MODE_CONTROL);
    chk(rd, 16'h0000);
    mf(MF_OP_WRITE, ADDR_PHY_CONTROL, 16'h4000);
    chk({14'h0000, mii_en, xover}, 16'h0003);
    mf(MF_OP_WRITE, ADDR_BASIC_MODE_CONTROL, 16'h0000);
    mf(MF_OP_WRITE, ADDR_BASIC_MODE_CONTROL, 16'h1000);
    wait_hi(quiet, 20);
  endtask : t_straps
  // watchdog well beyond the expected run of about 40 us
  initial begin
    #200_000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_neg();
    t_loss();
    t_forced();
    t_iso();
    t_straps();
    close_out();
  end
endmodule : phy_autoneg_config_tb_top
